// file: inc/eeprom_wr_pkg.sv
// shared constants and types for the two-wire eeprom write path
package eeprom_wr_pkg;
  // ******************************************
  // device address byte
  // ******************************************
  localparam logic [3:0] type_array = 4'ha;   // array space identifier
  localparam logic [3:0] type_alt = 4'hb;     // alternate space identifier
  localparam int dev_cs_pos = 3;              // chip select bit position
  localparam int dev_top_pos = 2;             // top array bit position
  localparam int dev_a16_pos = 1;             // next array bit position
  localparam int fsel_hi_pos = 2;             // function select in first word byte (bit 10)
  localparam int fsel_lo_pos = 1;             // function select (bit 9)
  // function select codes
  localparam logic [1:0] fsel_idpage = 2'h0;
  localparam logic [1:0] fsel_uid = 2'h1;
  localparam logic [1:0] fsel_lock = 2'h2;
  localparam logic [1:0] fsel_protect = 2'h3;
  // ******************************************
  // sizes and timing
  // ******************************************
  localparam int page_bytes = 256;            // page row size
  localparam int addr_w = 18;                 // byte address width
  localparam int clk_mhz = 40;                // mclk rate
  localparam int write_cycle_time_us = 3000;  // write cycle time, us
  localparam int write_cycle_cycles = write_cycle_time_us * clk_mhz;
  localparam int sclk_div = 50;               // master scl half period in mclk
  localparam logic [7:0] cnt_one = 8'h01;
endpackage : eeprom_wr_pkg

// file: inc/eeprom_bus_if.sv
// two-wire bus joining the eeprom write end and the master end
`timescale 1ns/10ps
interface eeprom_bus_if;
  logic scl_o;     // master clock drive level
  logic scl_oe_n;  // master clock enable, low drives
  logic m_sda_o;   // master data drive level
  logic m_sda_oe_n;
  logic s_sda_o;   // device data drive level
  logic s_sda_oe_n;
  logic scl;       // resolved wire levels
  logic sda;
  // open drain resolution with pull-ups
  assign scl = (!scl_oe_n && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o)) ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output s_sda_o, output s_sda_oe_n);
  modport master (input scl, input sda, output scl_o, output scl_oe_n,
                  output m_sda_o, output m_sda_oe_n);
endinterface : eeprom_bus_if

// file: verilog/eeprom_wr_dev.sv
// eeprom slave end: addressing, byte and page write, write cycle
`timescale 1ns/10ps
module eeprom_wr_dev #(
  parameter int write_cycles = eeprom_wr_pkg::write_cycle_cycles
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // straps and protect pin
  input wire logic chip_select_bit,
  input wire logic write_protect,
  // two-wire bus
  eeprom_bus_if.device bus,
  // memory write port, one byte per pulse
  output logic mem_we_q,
  output logic [17:0] mem_addr_q,
  output logic [7:0] mem_data_q,
  output logic alt_we_q,
  output logic [1:0] alt_func_q,
  output logic busy_q
);
  // ******************************************
  // types and state
  // ******************************************
  typedef enum logic [5:0] {
    st_idle = 6'b000001,  // standby, waiting for start
    st_dev = 6'b000010,   // device address byte
    st_wa1 = 6'b000100,   // first word address byte
    st_wa2 = 6'b001000,   // second word address byte
    st_data = 6'b010000,  // data bytes
    st_prog = 6'b100000   // programming from the page buffer
  } state_t;
  state_t state_q;
  logic [2:0] scl_s_q, sda_s_q;   // synchronisers plus one history stage
  logic scl_r, scl_f, start_c, stop_c;
  logic [3:0] bit_q;              // clock count within byte, 0..9
  logic [7:0] sh_q;               // shift register
  logic [7:0] dev_q, wa1_q;       // captured address bytes
  logic [7:0] low_q;              // page offset counter
  logic [8:0] cnt_q;              // bytes accepted
  logic alt_q, ack_q, refuse_q;
  logic [7:0] buf_q [0:eeprom_wr_pkg::page_bytes-1];  // page buffer
  logic [255:0] bval_q;           // buffer entry valid
  logic [31:0] wc_q;              // write cycle timer
  logic [7:0] pidx_q;             // program index
  logic tenth_q;                  // stop may land now: a byte was just acked
  logic drain_q;                  // buffer walk still running
  logic [1:0] wp_s_q, cs_s_q;     // protect pin and chip select strap synchronisers

  // ******************************************
  // pin synchronisation and bus events
  // ******************************************
  // two flops before use; stage 2 vs 3 gives edges
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      wp_s_q <= 2'h0;
      cs_s_q <= 2'h0;
    end else if (clk_en) begin
      scl_s_q <= {scl_s_q[1:0], bus.scl};
      sda_s_q <= {sda_s_q[1:0], bus.sda};
      // pins are asynchronous: two flops before any decision reads them
      wp_s_q <= {wp_s_q[0], write_protect};
      cs_s_q <= {cs_s_q[0], chip_select_bit};
    end
  end
  assign scl_r = scl_s_q[1] && !scl_s_q[2];
  assign scl_f = !scl_s_q[1] && scl_s_q[2];
  assign start_c = scl_s_q[1] && scl_s_q[2] && !sda_s_q[1] && sda_s_q[2];
  assign stop_c = scl_s_q[1] && scl_s_q[2] && sda_s_q[1] && !sda_s_q[2];

  // ******************************************
  // protocol state machine
  // ******************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= st_idle;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      dev_q <= 8'h00;
      wa1_q <= 8'h00;
      low_q <= 8'h00;
      cnt_q <= 9'h000;
      alt_q <= 1'b0;
      ack_q <= 1'b0;
      refuse_q <= 1'b0;
      tenth_q <= 1'b0;
      bval_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        st_prog: begin
          // bus is ignored completely while programming
          ack_q <= 1'b0;
          if (wc_q == 32'h0) state_q <= st_idle;
        end
        default: begin
          if (start_c) begin
            // a start always restarts addressing; unstopped data is dropped
            state_q <= st_dev;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            tenth_q <= 1'b0;
            bval_q <= '0;
            cnt_q <= 9'h000;
          end else if (stop_c) begin
            // program only when stop follows an acked data byte
            if (state_q == st_data && tenth_q && cnt_q != 9'h000) state_q <= st_prog;
            else begin
              state_q <= st_idle;
              bval_q <= '0;  // aborted sequence discards buffer
            end
            ack_q <= 1'b0;
          end else if (state_q != st_idle && scl_r) begin
            if (bit_q < 4'h8) begin
              sh_q <= {sh_q[6:0], sda_s_q[1]};
              bit_q <= bit_q + 4'h1;
            end else bit_q <= 4'h9;
          end else if (state_q != st_idle && scl_f) begin
            // the stop slot spans the whole tenth clock; its falling edge closes it
            tenth_q <= 1'b0;
            if (bit_q == 4'h8) begin
              // byte complete: decide ack for the ninth clock
              case (state_q)
                st_dev: begin
                  // type and chip select must match, write only
                  if ((sh_q[7:4] == eeprom_wr_pkg::type_array ||
                       sh_q[7:4] == eeprom_wr_pkg::type_alt) &&
                      sh_q[eeprom_wr_pkg::dev_cs_pos] == cs_s_q[1] && !sh_q[0]) begin
                    ack_q <= 1'b1;
                    dev_q <= sh_q;
                    alt_q <= (sh_q[7:4] == eeprom_wr_pkg::type_alt);
                  end else state_q <= st_idle;  // nack, back to standby
                end
                st_wa1: begin
                  ack_q <= 1'b1;
                  wa1_q <= sh_q;
                end
                st_wa2: begin
                  ack_q <= 1'b1;
                  low_q <= sh_q;
                end
                st_data: begin
                  // protected bytes are nacked and not stored
                  refuse_q <= wp_s_q[1];
                  if (!wp_s_q[1]) begin
                    ack_q <= 1'b1;
                    bval_q[low_q] <= 1'b1;  // later bytes overwrite on wrap
                    low_q <= low_q + 8'h01;  // low byte only
                    if (cnt_q != 9'h100) cnt_q <= cnt_q + 9'h001;
                  end
                end
                default: ack_q <= 1'b0;
              endcase
            end else if (bit_q == 4'h9) begin
              // end of ninth clock: release and move on
              bit_q <= 4'h0;
              ack_q <= 1'b0;
              if (state_q == st_data) tenth_q <= !refuse_q;
              case (state_q)
                st_dev: state_q <= st_wa1;
                st_wa1: state_q <= st_wa2;
                st_wa2: state_q <= st_data;
                default: state_q <= state_q;
              endcase
            end
          end
        end
      endcase
    end
  end

  // page buffer store, written as data bytes are acked
  always_ff @(posedge mclk) begin
    if (clk_en && state_q == st_data && scl_f && bit_q == 4'h8 && !wp_s_q[1] &&
        !start_c && !stop_c)
      buf_q[low_q] <= sh_q;
  end

  // ******************************************
  // write cycle timer and memory port
  // ******************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wc_q <= 32'h0;
      pidx_q <= 8'h00;
      drain_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 18'h00000;
      mem_data_q <= 8'h00;
      alt_we_q <= 1'b0;
      alt_func_q <= 2'h0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      mem_we_q <= 1'b0;
      alt_we_q <= 1'b0;
      if (state_q != st_prog) begin
        wc_q <= 32'(write_cycles);
        pidx_q <= 8'h00;
        drain_q <= 1'b1;
        busy_q <= 1'b0;
      end else begin
        busy_q <= 1'b1;
        if (wc_q != 32'h0) wc_q <= wc_q - 32'h1;
        // visit offsets 0..255 once each; needs write_cycles of 255 or more
        if (drain_q) begin
          pidx_q <= pidx_q + 8'h01;
          if (pidx_q == 8'hff) drain_q <= 1'b0;
          if (bval_q[pidx_q]) begin
            // array: {dev bits 2:1, word1, offset}
            mem_addr_q <= {dev_q[eeprom_wr_pkg::dev_top_pos], dev_q[eeprom_wr_pkg::dev_a16_pos],
                           wa1_q, pidx_q};
            mem_data_q <= buf_q[pidx_q];
            mem_we_q <= !alt_q;
            // alternate space: bits 10:9 select function
            alt_we_q <= alt_q;
            alt_func_q <= {wa1_q[eeprom_wr_pkg::fsel_hi_pos], wa1_q[eeprom_wr_pkg::fsel_lo_pos]};
          end
        end
      end
    end
  end

  // ack drive: oe low pulls the line low for the whole ninth clock
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe_n = !ack_q;
endmodule : eeprom_wr_dev

// file: verilog/eeprom_wr_master.sv
// two-wire master end issuing byte and page writes
`timescale 1ns/10ps
module eeprom_wr_master (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // command: start a write of len bytes at dev/addr
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_dev,
  input wire logic [15:0] cmd_addr,
  input wire logic [8:0] cmd_len,
  input wire logic [7:0] wr_data,
  // status
  output logic cmd_ready_q,
  output logic data_take_q,
  output logic done_q,
  output logic nack_q,
  // two-wire bus
  eeprom_bus_if.master bus
);
  // ******************************************
  // state
  // ******************************************
  typedef enum logic [3:0] {
    m_idle = 4'b0001, m_start = 4'b0010, m_byte = 4'b0100,
    m_stop = 4'b1000
  } mstate_t;
  mstate_t st_q;
  logic [7:0] div_q;
  logic ph_q;                   // half-phase: 0 high, 1 low
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [1:0] idx_q;            // 0 dev, 1 hi, 2 lo, 3 data
  logic [8:0] left_q;
  logic [15:0] addr_q;
  logic [7:0] dev_q;
  logic scl_q, sda_q;
  logic [1:0] sda_s_q;          // returned data synchroniser
  logic tick;

  assign tick = (div_q == 8'(eeprom_wr_pkg::sclk_div - 1));

  // sample acknowledge through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) sda_s_q <= 2'h3;
    else if (clk_en) sda_s_q <= {sda_s_q[0], bus.sda};
  end

  // ******************************************
  // sequencer: start, dev, two word bytes, data, stop
  // ******************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= m_idle;
      div_q <= 8'h00;
      ph_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= 2'h0;
      left_q <= 9'h000;
      addr_q <= 16'h0000;
      dev_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cmd_ready_q <= 1'b0;
      data_take_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (clk_en) begin
      data_take_q <= 1'b0;
      done_q <= 1'b0;
      cmd_ready_q <= (st_q == m_idle) && !cmd_valid;
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      case (st_q)
        m_idle: begin
          scl_q <= 1'b1;
          sda_q <= 1'b1;
          if (cmd_valid && cmd_ready_q) begin
            // type, address and write bit zero
            dev_q <= {cmd_dev[7:1], 1'b0};
            addr_q <= cmd_addr;
            left_q <= cmd_len;  // up to 256 data bytes
            nack_q <= 1'b0;
            st_q <= m_start;
            div_q <= 8'h00;
          end
        end
        m_start: if (tick) begin
          sda_q <= 1'b0;  // data falls while clock high
          ph_q <= 1'b0;
          bit_q <= 4'h0;
          idx_q <= 2'h0;
          sh_q <= dev_q;
          st_q <= m_byte;
        end
        m_byte: if (tick) begin
          ph_q <= !ph_q;
          if (!ph_q) begin
            scl_q <= 1'b0;
            // release line on ninth clock for the device ack
            sda_q <= (bit_q == 4'h8) ? 1'b1 : sh_q[7];
          end else begin
            scl_q <= 1'b1;
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (sda_s_q[1]) begin
                // nack: stop and report; a busy device is polled by a fresh command
                nack_q <= 1'b1;
                st_q <= m_stop;
              end else if (idx_q == 2'h3) begin
                left_q <= left_q - 9'h001;
                if (left_q == 9'h001) st_q <= m_stop;  // stop in tenth clock
                else begin
                  sh_q <= wr_data;
                  data_take_q <= 1'b1;
                end
              end else begin
                idx_q <= idx_q + 2'h1;
                sh_q <= (idx_q == 2'h0) ? addr_q[15:8] : (idx_q == 2'h1) ? addr_q[7:0] : wr_data;
                if (idx_q == 2'h2) data_take_q <= 1'b1;
              end
            end else begin
              bit_q <= bit_q + 4'h1;
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
        end
        m_stop: if (tick) begin
          if (!scl_q) scl_q <= 1'b1;  // tenth clock rises with data held low
          else if (sda_q) begin
            // close the ninth clock and pull data low
            scl_q <= 1'b0;
            sda_q <= 1'b0;
          end else begin
            sda_q <= 1'b1;  // data rises while clock high
            done_q <= 1'b1;
            st_q <= m_idle;
          end
        end
        default: st_q <= m_idle;
      endcase
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe_n = scl_q;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe_n = sda_q;
endmodule : eeprom_wr_master

// file: verification/eeprom_wr_assertions.sv
// bus and write-port assertions for the eeprom write path
`timescale 1ns/10ps
module eeprom_wr_checker #(
  parameter int write_cycles = 1500
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // wire levels and device drive
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe_n,
  // device write side
  input wire logic busy_q,
  input wire logic mem_we_q,
  input wire logic [17:0] mem_addr_q
);
  // ************
  // helper state
  // ************
  logic scl_q, sda_q; // wire levels one cycle back
  logic [3:0] bit_q; // scl rises in the current byte, cleared on start and at the ninth rise
  int busy_n_q; // cycles spent busy
  logic seen_q; // a byte already went out this cycle
  logic [9:0] row_q; // page row of that first byte
  // bit count, cleared on start so an ack lines up with the ninth clock
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_q <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        bit_q <= 4'h0;
      end else if (scl && !scl_q) begin
        bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      end
    end
  end
  // busy length and page row of the programming burst
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_n_q <= 0;
      seen_q <= 1'b0;
      row_q <= 10'h000;
    end else begin
      busy_n_q <= busy_q ? busy_n_q + 1 : 0;
      seen_q <= busy_q && (seen_q || mem_we_q);
      if (mem_we_q && !seen_q) begin
        row_q <= mem_addr_q[17:8];
      end
    end
  end
  // ************
  // assertions
  // ************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ack_bit_a: assert property ($fell(s_sda_oe_n) |-> bit_q == 4'h8)
    else $error("ack not after eighth bit");
  ack_hold_a: assert property ($rose(scl) && !s_sda_oe_n |=> !s_sda_oe_n [*8])
    else $error("ack dropped while clock high");
  ack_span_a: assert property ($fell(s_sda_oe_n) |-> ##[50:150] $rose(s_sda_oe_n))
    else $error("ack length wrong");
  busy_quiet_a: assert property (busy_q |-> s_sda_oe_n)
    else $error("ack while busy");
  write_window_a: assert property (mem_we_q |-> busy_q)
    else $error("array write outside write cycle");
  stop_launch_a: assert property ($rose(busy_q) |-> scl && sda && bit_q == 4'h1)
    else $error("write cycle without tenth clock stop");
  busy_len_a: assert property ($fell(busy_q) |->
    busy_n_q >= write_cycles - 1 && busy_n_q <= write_cycles + 1)
    else $error("write cycle length wrong");
  burst_span_a: assert property (mem_we_q |-> busy_n_q < 260)
    else $error("buffer flushed late");
  page_row_a: assert property (mem_we_q && seen_q |-> mem_addr_q[17:8] == row_q)
    else $error("page row changed in burst");
  cover property ($rose(busy_q));
  cover property (mem_we_q && seen_q);
  cover property ($fell(s_sda_oe_n) && bit_q == 4'h8);
endmodule : eeprom_wr_checker

// file: verification/test_serial_eeprom_write_addressing.sv
// bench joining the eeprom write end to the master end
`timescale 1ns/10ps
module test_serial_eeprom_write_addressing;
  // ******************
  // signals and blocks
  // ******************
  localparam int wcyc = 1500; // shortened write cycle
  localparam int half = eeprom_wr_pkg::sclk_div; // bit-bang half period
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cs_strap = 1'b1; // chip select strap, driven low for one write
  logic write_protect = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_dev = 8'h00;
  logic [15:0] cmd_addr = 16'h0000;
  logic [8:0] cmd_len = 9'h001;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready_q, data_take_q, done_q, nack_q, mem_we_q, alt_we_q, busy_q, mem_we2;
  logic [17:0] mem_addr_q, mem_addr2;
  logic [7:0] mem_data_q, mem_data2;
  logic [1:0] alt_func_q;
  int errors = 0;
  int checked = 0;
  logic [25:0] wq[$]; // array bytes seen, address and data
  logic [1:0] aq[$]; // alternate functions seen
  int we2_n; // writes of the second device
  logic [25:0] we2_last;
  always #12.5 mclk = ~mclk;
  eeprom_bus_if bus();
  eeprom_bus_if bus2(); // bench plays master here, free to break the framing
  eeprom_wr_dev #(.write_cycles(wcyc)) i_eeprom_wr_dev (.mclk(mclk), .rstn(rstn),
    .clk_en(1'b1), .chip_select_bit(cs_strap), .write_protect(write_protect), .bus(bus),
    .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_data_q(mem_data_q),
    .alt_we_q(alt_we_q), .alt_func_q(alt_func_q), .busy_q(busy_q));
  eeprom_wr_dev #(.write_cycles(wcyc)) i_eeprom_wr_dev_2 (.mclk(mclk), .rstn(rstn),
    .clk_en(1'b1), .chip_select_bit(cs_strap), .write_protect(write_protect), .bus(bus2),
    .mem_we_q(mem_we2), .mem_addr_q(mem_addr2), .mem_data_q(mem_data2),
    .alt_we_q(), .alt_func_q(), .busy_q());
  eeprom_wr_master i_eeprom_wr_master (.mclk(mclk), .rstn(rstn), .clk_en(1'b1),
    .cmd_valid(cmd_valid), .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .wr_data(wr_data), .cmd_ready_q(cmd_ready_q), .data_take_q(data_take_q),
    .done_q(done_q), .nack_q(nack_q), .bus(bus));
  eeprom_wr_checker #(.write_cycles(wcyc)) i_eeprom_wr_checker (.mclk(mclk), .rstn(rstn),
    .scl(bus.scl), .sda(bus.sda), .s_sda_oe_n(bus.s_sda_oe_n), .busy_q(busy_q),
    .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q));
  // capture write pulses, they stand one cycle only
  always @(posedge mclk) begin
    if (mem_we_q === 1'b1) wq.push_back({mem_addr_q, mem_data_q});
    if (alt_we_q === 1'b1) aq.push_back(alt_func_q);
    if (mem_we2 === 1'b1) we2_n++;
    if (mem_we2 === 1'b1) we2_last = {mem_addr2, mem_data2};
  end
  // ******************
  // shared tasks
  // ******************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  // one master command; next byte offered after each take pulse
  task automatic run_cmd(input logic [7:0] d, input logic [15:0] a, input logic [8:0] n,
                         input logic [7:0] b);
    int t;
    int k;
    t = 0;
    k = 0;
    while (cmd_ready_q !== 1'b1 && t < 500) begin
      @(posedge mclk);
      t++;
    end
    cmd_dev <= d;
    cmd_addr <= a;
    cmd_len <= n;
    wr_data <= b;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    while (done_q !== 1'b1 && t < 20000) begin
      @(posedge mclk);
      t++;
      if (data_take_q === 1'b1) begin
        k++;
        wr_data <= b + k[7:0];
      end
    end
    check(t < 20000, 1'b1, "command hang");
  endtask : run_cmd
  // wait out a write cycle if one starts
  task automatic settle(input logic launch);
    int t;
    t = 0;
    while (busy_q !== 1'b1 && t < 40) begin
      @(posedge mclk);
      t++;
    end
    if (launch === 1'b1) check(busy_q, 1'b1, "no write cycle");
    t = 0;
    while (busy_q === 1'b1 && t < wcyc + 300) begin
      @(posedge mclk);
      t++;
    end
    check(busy_q, 1'b0, "write cycle stuck");
  endtask : settle
  // write and check every byte lands in the same page row
  task automatic do_write(input logic [7:0] d, input logic [15:0] a, input logic [8:0] n,
                          input logic [7:0] b, input logic refuse);
    int k;
    int hit;
    logic [25:0] e;
    wq.delete();
    run_cmd(d, a, n, b);
    check(nack_q, refuse, "ack outcome");
    settle(!refuse);
    check(wq.size(), refuse ? 32'h0 : 32'(n), "byte count");
    for (k = 0; k < n && !refuse; k++) begin
      e = {d[2], d[1], a[15:8], a[7:0] + k[7:0], b + k[7:0]};
      hit = 0;
      foreach (wq[j]) begin
        if (wq[j] === e) hit++;
      end
      check(hit, 32'h1, "byte placement");
    end
  endtask : do_write
  // bit-bang one clock on the second bus, sampling sda mid-high
  task automatic bb_bit(input logic b, output logic s);
    repeat (half / 2) @(posedge mclk);
    bus2.m_sda_oe_n <= b;
    repeat (half / 2) @(posedge mclk);
    bus2.scl_oe_n <= 1'b1;
    repeat (half / 2) @(posedge mclk);
    s = bus2.sda;
    repeat (half / 2) @(posedge mclk);
    bus2.scl_oe_n <= 1'b0;
  endtask : bb_bit
  task automatic bb_byte(input logic [7:0] v);
    int i;
    logic s;
    for (i = 7; i >= 0; i--) bb_bit(v[i], s);
    bb_bit(1'b1, s);
    check(s, 1'b0, "no ack");
  endtask : bb_byte
  // ******************
  // scenarios
  // ******************
  // byte write with extra clocks before the stop
  task automatic bb_frame(input int extra);
    int i;
    logic s;
    we2_n = 0;
    bus2.m_sda_oe_n <= 1'b0;
    repeat (half) @(posedge mclk);
    bus2.scl_oe_n <= 1'b0;
    bb_byte(8'hac);
    bb_byte(8'h12);
    bb_byte(8'h34);
    bb_byte(8'h55);
    for (i = 0; i < extra; i++) bb_bit(1'b0, s);
    repeat (half / 2) @(posedge mclk);
    bus2.m_sda_oe_n <= 1'b0;
    repeat (half / 2) @(posedge mclk);
    bus2.scl_oe_n <= 1'b1;
    repeat (half) @(posedge mclk);
    bus2.m_sda_oe_n <= 1'b1;
    repeat (wcyc + 400) @(posedge mclk);
    check(we2_n, (extra == 0) ? 32'h1 : 32'h0, "stop placement");
    if (extra == 0) check(we2_last, {2'b10, 8'h12, 8'h34, 8'h55}, "frame write");
  endtask : bb_frame
  // each function select code of the alternate space
  task automatic alt_funcs;
    logic [1:0] codes[4];
    int i;
    codes = '{eeprom_wr_pkg::fsel_idpage, eeprom_wr_pkg::fsel_uid,
              eeprom_wr_pkg::fsel_lock, eeprom_wr_pkg::fsel_protect};
    for (i = 0; i < 4; i++) begin
      aq.delete();
      wq.delete();
      run_cmd(8'hb8, {5'h1f, i[1:0], 9'h1ff}, 9'h001, 8'h02);
      settle(1'b0);
      check(aq.size(), 32'h1, "alt write count");
      check(aq[0], codes[i], "function select");
      check(wq.size(), 32'h0, "alt wrote array");
    end
  endtask : alt_funcs
  // second command lands inside the write cycle, then a poll succeeds
  task automatic busy_poll;
    wq.delete();
    run_cmd(8'hac, 16'h0010, 9'h001, 8'h21);
    run_cmd(8'hac, 16'h0011, 9'h001, 8'h22);
    check(nack_q, 1'b1, "acked while busy");
    settle(1'b0);
    check(wq.size(), 32'h1, "busy write count");
    do_write(8'hac, 16'h0011, 9'h001, 8'h22, 1'b0);
  endtask : busy_poll
  task automatic conclude;
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // hang guard, about a quarter above the expected run
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude;
  end
  // main sequence
  initial begin
    bus2.scl_o = 1'b0;
    bus2.m_sda_o = 1'b0;
    bus2.scl_oe_n = 1'b1;
    bus2.m_sda_oe_n = 1'b1;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    do_write(8'hac, 16'h5a3c, 9'h001, 8'h96, 1'b0);
    do_write(8'haa, 16'h31fe, 9'h005, 8'h10, 1'b0);
    write_protect <= 1'b1;
    do_write(8'hac, 16'h0100, 9'h001, 8'h40, 1'b1);
    do_write(8'hac, 16'h0200, 9'h003, 8'h50, 1'b1);
    write_protect <= 1'b0;
    do_write(8'ha4, 16'h0300, 9'h001, 8'h60, 1'b1);
    do_write(8'h2c, 16'h0300, 9'h001, 8'h61, 1'b1);
    cs_strap <= 1'b0;
    do_write(8'ha6, 16'h0400, 9'h001, 8'h70, 1'b0);
    cs_strap <= 1'b1;
    alt_funcs;
    busy_poll;
    bb_frame(1);
    bb_frame(4);
    bb_frame(0);
    conclude;
  end
endmodule : test_serial_eeprom_write_addressing
